// File: dv/phase_voltage_rx_supervisor_bench.sv
module phase_voltage_rx_supervisor_bench
  import svrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 50;
  localparam int PER  = 40;
  localparam int WLIM = 10;

  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, local_sync_ns = 32'h00000064, frame_sync_ns;
  logic pready, pslverr, frame_valid, frame_sync_known, rx_valid, local_out_valid;
  logic local_sync_known = 1'b1, adapt_supported = 1'b0, adapt_ready = 1'b1;
  logic local_valid = 1'b0, breaker_open_in = 1'b0, run = 1'b0, skip_load = 1'b0;
  logic alarm, warning, fuse_fail_block_out, irq;
  logic [1:0] skip_n = 2'h0;
  logic [QUAL_W-1:0] qual_in = '0, frame_quality;
  logic signed [31:0] frame_phase_a, frame_phase_b, frame_phase_c, frame_residual;
  logic signed [31:0] phase_a_sample, phase_b_sample, phase_c_sample, residual_sample;
  logic signed [3:0][31:0] local_in = '0, local_out;
  logic signed [31:0] cap [4];
  int failures = 0, checks_done = 0, n;

  // ---------------------------------------------------------------
  // clock, instances, capture of sent frames
  // ---------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;

  phase_voltage_rx_supervisor #(.HOLD_CYCLES(32'(HOLD))) dut (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_valid, .frame_phase_a, .frame_phase_b, .frame_phase_c,
    .frame_residual, .frame_quality, .frame_sync_known, .frame_sync_ns,
    .local_sync_known, .local_sync_ns, .adapt_supported, .adapt_ready, .local_valid,
    .local_in, .breaker_open_in, .rx_valid, .phase_a_sample, .phase_b_sample,
    .phase_c_sample, .residual_sample, .local_out_valid, .local_out, .alarm,
    .warning, .fuse_fail_block_out, .irq);

  sampled_value_sender #(.PERIOD(PER)) sender (
    .sys_clk, .rst, .run, .skip_load, .skip_n, .qual_in, .frame_valid,
    .frame_phase_a, .frame_phase_b, .frame_phase_c, .frame_residual,
    .frame_quality, .frame_sync_known, .frame_sync_ns);

  always @(posedge sys_clk) begin
    if (frame_valid === 1'b1) begin
      cap <= '{frame_phase_a, frame_phase_b, frame_phase_c, frame_residual};
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input string name);
    failures++;
    $display("MISMATCH %s expected response seen timeout", name);
    give_verdict();
  endtask

  // apb transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] mask);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(name, rd & mask, exp);
  endtask

  // 0 alarm, 1 warning, 2 fuse, 3 irq, 4 rx_valid, 5 local_out_valid, else alarm or warning
  function automatic logic pick(input int s);
    case (s)
      0: return alarm;
      1: return warning;
      2: return fuse_fail_block_out;
      3: return irq;
      4: return rx_valid;
      5: return local_out_valid;
      default: return alarm | warning;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic v, output int k);
    k = 0;
    while (pick(s) !== v) begin
      @(posedge sys_clk);
      k++;
      if (k > 2000) timeout("wait");
    end
  endtask

  task automatic quiet(input int cycles, output int highs);
    highs = 0;
    repeat (cycles) begin
      @(posedge sys_clk);
      if (pick(6) !== 1'b0) highs++;
    end
  endtask

  task automatic cmp_samples();
    check("phase_a", phase_a_sample, cap[0]);
    check("phase_b", phase_b_sample, cap[1]);
    check("phase_c", phase_c_sample, cap[2]);
    check("residual", residual_sample, cap[3]);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic        err;
    check("alarm at reset", alarm, 1'b1);
    check("fuse idle", fuse_fail_block_out, 1'b0);
    check("phase_a reset", phase_a_sample, 32'h0);
    rdc("ctrl", ADDR_CTRL, 32'h0, 32'hffffffff);
    rdc("period", ADDR_PERIOD, PERIOD_RST, 32'hffffffff);
    rdc("wait", ADDR_WAIT, WAIT_RST, 32'hffffffff);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    wr(ADDR_PERIOD, 32'(PER));
    wr(ADDR_WAIT, 32'(WLIM));
    rdc("wait set", ADDR_WAIT, 32'(WLIM), 32'hffffffff);
    $display("reset test done");
  endtask

  task automatic t_start();
    wait_for(4, 1'b1, n);
    cmp_samples();
    wait_for(0, 1'b0, n);
    check("warning clear", warning, 1'b0);
    $display("start test done");
  endtask

  task automatic t_sync();
    local_sync_ns <= 32'h00000fa1;
    wait_for(1, 1'b1, n);
    check("warn delay", n <= 3, 1'b1);
    check("no alarm", alarm, 1'b0);
    local_sync_ns <= SYNC_WARN_NS;
    wait_for(1, 1'b0, n);
    check("warn held", n >= HOLD && n <= HOLD + 4, 1'b1);
    local_sync_known <= 1'b0;
    wait_for(0, 1'b1, n);
    check("alarm delay", n <= 3, 1'b1);
    check("warn with alarm", warning, 1'b1);
    local_sync_known <= 1'b1;
    wait_for(6, 1'b0, n);
    $display("sync test done");
  endtask

  task automatic t_loss();
    int highs;
    wait_for(4, 1'b1, n);
    skip_n <= 2'h1;
    skip_load <= 1'b1;
    @(posedge sys_clk);
    skip_load <= 1'b0;
    wait_for(4, 1'b1, n);
    check("repeat slot", n >= PER + WLIM - 4 && n <= PER + WLIM + 2, 1'b1);
    cmp_samples();
    quiet(2 * PER, highs);
    check("single loss quiet", highs, 32'h0);
    skip_n <= 2'h2;
    skip_load <= 1'b1;
    @(posedge sys_clk);
    skip_load <= 1'b0;
    wait_for(0, 1'b1, n);
    check("double loss", n > PER + WLIM && n <= 2 * PER + WLIM + 4, 1'b1);
    check("warn with alarm", warning, 1'b1);
    wait_for(6, 1'b0, n);
    $display("loss test done");
  endtask

  task automatic t_quality();
    int highs;
    logic [QUAL_W-1:0] q [2];
    q = '{QUAL_W'(1) << QUAL_TEST_BIT, QUAL_W'(1) << QUAL_DERIVED_BIT};
    qual_in <= QUAL_W'(1);
    wait_for(0, 1'b1, n);
    check("bad quality warn", warning, 1'b1);
    qual_in <= '0;
    wait_for(4, 1'b1, n);
    wait_for(0, 1'b0, n);
    check("quality hold", n >= HOLD && n <= HOLD + 4, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, (i == 0) ? 32'h1 : 32'h0);
      qual_in <= q[i];
      quiet(3 * PER, highs);
      check("accepted quality", highs, 32'h0);
      qual_in <= '0;
      repeat (2 * PER) @(posedge sys_clk);
    end
    $display("quality test done");
  endtask

  task automatic t_adapt();
    adapt_supported <= 1'b1;
    adapt_ready <= 1'b0;
    wr(ADDR_CTRL, 32'h2);
    wait_for(1, 1'b1, n);
    check("adapt warn", n <= 4, 1'b1);
    check("adapt no alarm", alarm, 1'b0);
    adapt_ready <= 1'b1;
    wait_for(1, 1'b0, n);
    wr(ADDR_CTRL, 32'h0);
    $display("adapt test done");
  endtask

  task automatic t_breaker();
    breaker_open_in <= 1'b1;
    wait_for(2, 1'b1, n);
    check("fuse delay", n >= 2 && n <= 5, 1'b1);
    rdc("breaker event", ADDR_IRQ_STATUS, 32'h20, 32'h20);
    check("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h20);
    wait_for(3, 1'b1, n);
    check("irq raise", n <= 3, 1'b1);
    breaker_open_in <= 1'b0;
    wr(ADDR_IRQ_STATUS, 32'h20);
    wait_for(3, 1'b0, n);
    check("irq clear", n <= 3, 1'b1);
    rdc("event cleared", ADDR_IRQ_STATUS, 32'h0, 32'h20);
    wait_for(2, 1'b0, n);
    $display("breaker test done");
  endtask

  task automatic t_local();
    local_in <= {32'sd4, -32'sd3, 32'sd2, -32'sd1};
    local_valid <= 1'b1;
    @(posedge sys_clk);
    local_valid <= 1'b0;
    wait_for(5, 1'b1, n);
    check("local delay", n >= WLIM, 1'b1);
    for (int i = 0; i < 4; i++) begin
      check("local sample", local_out[i], local_in[i]);
    end
    $display("local test done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    run <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_start();
    t_sync();
    t_loss();
    t_quality();
    t_adapt();
    t_breaker();
    t_local();
    give_verdict();
  end
endmodule

// File: dv/sampled_value_sender.sv
// ---------------------------------------------------------------
// remote sender model: one frame every PERIOD cycles
// ---------------------------------------------------------------
module sampled_value_sender
  import svrx_pkg::*;
#(
  parameter int PERIOD = 40
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               run,
  input  wire logic               skip_load,
  input  wire logic [1:0]         skip_n,
  input  wire logic [QUAL_W-1:0]  qual_in,
  output logic                    frame_valid,
  output logic signed [31:0]      frame_phase_a,
  output logic signed [31:0]      frame_phase_b,
  output logic signed [31:0]      frame_phase_c,
  output logic signed [31:0]      frame_residual,
  output logic [QUAL_W-1:0]       frame_quality,
  output logic                    frame_sync_known,
  output logic [31:0]             frame_sync_ns
);
  timeunit 1ns;
  timeprecision 1ps;

  int                cnt;
  logic signed [31:0] seq;
  logic [1:0]        skip_left;

  // slot timer, skipped slots and frame fields; lines invert once in the cycle after each frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      seq <= 32'sd1;
      skip_left <= 2'h0;
      frame_valid <= 1'b0;
      {frame_phase_a, frame_phase_b, frame_phase_c, frame_residual} <= '0;
      {frame_quality, frame_sync_known, frame_sync_ns} <= '0;
    end else begin
      frame_valid <= 1'b0;
      if (frame_valid) begin
        {frame_phase_a, frame_phase_b, frame_phase_c, frame_residual} <=
          ~{frame_phase_a, frame_phase_b, frame_phase_c, frame_residual};
        {frame_quality, frame_sync_known, frame_sync_ns} <=
          ~{frame_quality, frame_sync_known, frame_sync_ns};
      end
      if (run) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        if (cnt == PERIOD - 1 && skip_left != 2'h0) begin
          skip_left <= skip_left - 2'h1;
        end else if (cnt == PERIOD - 1) begin
          frame_valid <= 1'b1;
          frame_phase_a <= seq;
          frame_phase_b <= -seq;
          frame_phase_c <= seq * 3;
          frame_residual <= seq * 5;
          frame_quality <= qual_in;
          frame_sync_known <= 1'b1;
          frame_sync_ns <= 32'h000003e8;
          seq <= seq + 32'sd1;
        end
      end
      if (skip_load) begin
        skip_left <= skip_n;
      end
    end
  end
endmodule

// File: hdl/delay_ram.sv
module delay_ram
  import svrx_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                wr_en,
  input  wire logic [FIFO_AW-1:0]  wr_addr,
  input  wire logic [FIFO_W-1:0]   wr_data,
  input  wire logic [FIFO_AW-1:0]  rd_addr,
  output logic      [FIFO_W-1:0]   rd_data
);

  logic [FIFO_W-1:0] mem [2**FIFO_AW];

  // write port, no reset on storage
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: hdl/phase_voltage_rx_supervisor.sv
// Implementation choices: the register addresses and the APB register port.
module phase_voltage_rx_supervisor
  import svrx_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = 32'(HOLD_CYCLES_L)
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     frame_valid,
  input  wire logic signed [31:0]       frame_phase_a,
  input  wire logic signed [31:0]       frame_phase_b,
  input  wire logic signed [31:0]       frame_phase_c,
  input  wire logic signed [31:0]       frame_residual,
  input  wire logic [QUAL_W-1:0]        frame_quality,
  input  wire logic                     frame_sync_known,
  input  wire logic [31:0]              frame_sync_ns,
  input  wire logic                     local_sync_known,
  input  wire logic [31:0]              local_sync_ns,
  input  wire logic                     adapt_supported,
  input  wire logic                     adapt_ready,
  input  wire logic                     local_valid,
  input  wire logic signed [3:0][31:0]  local_in,
  input  wire logic                     breaker_open_in,
  output logic                          rx_valid,
  output logic signed [31:0]            phase_a_sample,
  output logic signed [31:0]            phase_b_sample,
  output logic signed [31:0]            phase_c_sample,
  output logic signed [31:0]            residual_sample,
  output logic                          local_out_valid,
  output logic signed [3:0][31:0]       local_out,
  output logic                          alarm,
  output logic                          warning,
  output logic                          fuse_fail_block_out,
  output logic                          irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                brk_sync;
    logic                      fuse;
    logic                      test_mode;
    logic                      adapt_en;
    logic [31:0]               frame_period;
    logic [31:0]               wait_limit;
    logic [N_EVT-1:0]          irq_status;
    logic [N_EVT-1:0]          irq_mask;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               since;
    logic [1:0]                miss_cnt;
    logic signed [3:0][31:0]   samples;
    logic                      rx_valid;
    logic                      sender_known;
    logic [31:0]               sender_ns;
    logic                      qual_bad;
    logic [N_CAUSE-1:0][31:0]  hold_cnt;
    logic                      alarm;
    logic                      warning;
    logic                      irq;
    logic [31:0]               now;
    logic [FIFO_AW:0]          wr_ptr;
    logic [FIFO_AW:0]          rd_ptr;
    logic                      stale;
    logic signed [3:0][31:0]   local_out;
    logic                      local_out_valid;
  } state_t;

  state_t st;
  state_t next_st;

  logic [FIFO_W-1:0]   rd_data;
  logic                fifo_wr;
  logic [N_CAUSE-1:0]  cond;
  logic [N_CAUSE-1:0]  held;
  logic [N_EVT-1:0]    evt;
  logic [N_EVT-1:0]    clr;
  logic                first_acc;
  logic                zoh;
  logic                deadline;
  logic [FIFO_AW:0]    fill;
  logic                pop;
  logic [QUAL_W-1:0]   qual_mask;
  logic [31:0]         age;

  // local sample delay storage
  delay_ram u_delay_ram (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (fifo_wr),
    .wr_addr (st.wr_ptr[FIFO_AW-1:0]),
    .wr_data ({st.now, local_in}),
    .rd_addr (st.rd_ptr[FIFO_AW-1:0]),
    .rd_data (rd_data)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    clr = '0;
    zoh = 1'b0;
    next_st.rx_valid = 1'b0;
    next_st.local_out_valid = 1'b0;
    next_st.now = st.now + 32'h00000001;

    // breaker pin: stage 0 only feeds stage 1
    next_st.brk_sync = {st.brk_sync[1:0], breaker_open_in};
    if (st.brk_sync[1] == st.brk_sync[2]) begin
      next_st.fuse = st.brk_sync[2];
    end

    // raw conditions
    cond = '0;
    cond[C_SYNC_ALM] = ~st.sender_known | ~local_sync_known
                     | (st.sender_ns > SYNC_ALARM_NS)
                     | (local_sync_ns > SYNC_ALARM_NS);
    cond[C_FRAME_ALM] = st.miss_cnt[1];
    cond[C_QUAL] = st.qual_bad;
    cond[C_SYNC_WARN] = (st.sender_ns > SYNC_WARN_NS)
                      | (local_sync_ns > SYNC_WARN_NS);
    cond[C_ADAPT] = adapt_supported & st.adapt_en & ~adapt_ready;

    // per-cause hold stretchers, reloaded while the cause is present
    for (int i = 0; i < N_CAUSE; i++) begin
      held[i] = cond[i] | (st.hold_cnt[i] != '0);
      if (cond[i]) begin
        next_st.hold_cnt[i] = HOLD_CYCLES;
      end else if (st.hold_cnt[i] != '0) begin
        next_st.hold_cnt[i] = st.hold_cnt[i] - 32'h00000001;
      end
    end
    next_st.alarm = held[C_SYNC_ALM] | held[C_FRAME_ALM] | held[C_QUAL];
    next_st.warning = next_st.alarm | held[C_QUAL] | held[C_SYNC_WARN]
                    | held[C_ADAPT];

    // apb: answer one cycle into the access phase
    first_acc = psel & penable & ~st.pready;
    next_st.pready = first_acc;
    next_st.pslverr = 1'b0;
    next_st.prdata = '0;
    if (first_acc) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_st.prdata[CTRL_TEST_MODE] = st.test_mode;
          next_st.prdata[CTRL_ADAPT_EN] = st.adapt_en;
        end
        ADDR_PERIOD: next_st.prdata = st.frame_period;
        ADDR_WAIT: next_st.prdata = st.wait_limit;
        ADDR_SUPV: begin
          next_st.prdata[SUPV_ALARM] = st.alarm;
          next_st.prdata[SUPV_WARN] = st.warning;
          next_st.prdata[SUPV_FUSE] = st.fuse;
          next_st.prdata[SUPV_CAUSE +: N_CAUSE] = held;
          next_st.prdata[SUPV_MISS +: 2] = st.miss_cnt;
        end
        ADDR_IRQ_STATUS: next_st.prdata[N_EVT-1:0] = st.irq_status;
        ADDR_IRQ_MASK: next_st.prdata[N_EVT-1:0] = st.irq_mask;
        default: next_st.pslverr = 1'b1;
      endcase
    end
    // writes take effect on the edge that completes the transfer
    if (psel & penable & st.pready & pwrite) begin
      unique case (paddr)
        ADDR_CTRL: begin
          next_st.test_mode = pwdata[CTRL_TEST_MODE];
          next_st.adapt_en = pwdata[CTRL_ADAPT_EN];
        end
        ADDR_PERIOD: next_st.frame_period = pwdata;
        ADDR_WAIT: next_st.wait_limit = pwdata;
        ADDR_IRQ_STATUS: clr = pwdata[N_EVT-1:0];
        ADDR_IRQ_MASK: next_st.irq_mask = pwdata[N_EVT-1:0];
        default: ;
      endcase
    end

    // quality screen: derived ignored, test ignored in test mode
    qual_mask = '1;
    qual_mask[QUAL_DERIVED_BIT] = 1'b0;
    if (st.test_mode) begin
      qual_mask[QUAL_TEST_BIT] = 1'b0;
    end

    // frame slot timing against period plus wait limit
    deadline = {1'b0, st.since} >= ({1'b0, st.frame_period} + {1'b0, st.wait_limit});
    if (frame_valid) begin
      next_st.since = '0;
      next_st.miss_cnt = '0;
      next_st.samples = {frame_residual, frame_phase_c, frame_phase_b, frame_phase_a};
      next_st.rx_valid = 1'b1;
      next_st.sender_known = frame_sync_known;
      next_st.sender_ns = frame_sync_ns;
      next_st.qual_bad = |(frame_quality & qual_mask);
    end else if (deadline) begin
      // slot missed: restart timing on the next expected slot
      next_st.since = st.since - st.frame_period;
      if (st.miss_cnt != 2'h3) begin
        next_st.miss_cnt = st.miss_cnt + 2'h1;
      end
      if (st.miss_cnt == 2'h0) begin
        zoh = 1'b1;
        next_st.rx_valid = 1'b1;
      end
    end else begin
      next_st.since = st.since + 32'h00000001;
    end

    // local sample delay line
    fill = st.wr_ptr - st.rd_ptr;
    fifo_wr = local_valid & ~fill[FIFO_AW];
    age = st.now - rd_data[FIFO_W-1:128];
    pop = (fill != '0) & ~st.stale & (age >= st.wait_limit);
    if (fifo_wr) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
      next_st.local_out = rd_data[127:0];
      next_st.local_out_valid = 1'b1;
    end
    // read data lags a pointer move or a write to the head slot
    next_st.stale = pop | (fifo_wr & (st.wr_ptr[FIFO_AW-1:0] == st.rd_ptr[FIFO_AW-1:0]));

    // interrupt events, set wins over write-one-to-clear
    evt = '0;
    evt[E_ALARM_SET] = next_st.alarm & ~st.alarm;
    evt[E_ALARM_CLR] = ~next_st.alarm & st.alarm;
    evt[E_WARN_SET] = next_st.warning & ~st.warning;
    evt[E_ZOH] = zoh;
    evt[E_OVERFLOW] = local_valid & fill[FIFO_AW];
    evt[E_BREAKER] = next_st.fuse & ~st.fuse;
    next_st.irq_status = (st.irq_status & ~clr) | evt;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.frame_period <= PERIOD_RST;
      st.wait_limit <= WAIT_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  assign rx_valid            = st.rx_valid;
  assign phase_a_sample      = st.samples[0];
  assign phase_b_sample      = st.samples[1];
  assign phase_c_sample      = st.samples[2];
  assign residual_sample     = st.samples[3];
  assign local_out_valid     = st.local_out_valid;
  assign local_out           = st.local_out;
  assign alarm               = st.alarm;
  assign warning             = st.warning;
  assign fuse_fail_block_out = st.fuse;
  assign irq                 = st.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_warn_with_alarm: assert property (alarm |-> warning)
    else $error("warning low while alarm high");
  a_sync_alarm: assert property (!local_sync_known |=> alarm)
    else $error("unknown local sync did not raise alarm");
  a_sync_warn: assert property
    (local_sync_known && local_sync_ns > SYNC_WARN_NS |=> warning)
    else $error("poor local sync did not raise warning");
  a_adapt_warn: assert property
    (adapt_supported && st.adapt_en && !adapt_ready |=> warning)
    else $error("adaptivity not ready without warning");
  a_two_miss_alarm: assert property (st.miss_cnt >= 2'h2 |=> alarm)
    else $error("two lost frames without alarm");
  a_zoh_repeat: assert property
    (!frame_valid && deadline && st.miss_cnt == 2'h0
     |=> rx_valid && $stable(phase_a_sample) && st.miss_cnt == 2'h1)
    else $error("single loss not bridged by held samples");
  a_quality_alarm: assert property
    (frame_valid && (frame_quality & qual_mask) != '0 |=> ##1 alarm && warning)
    else $error("bad quality did not raise alarm and warning");
  a_test_accept: assert property
    (frame_valid && st.test_mode && frame_quality == (QUAL_W'(1) << QUAL_TEST_BIT)
     |=> !st.qual_bad)
    else $error("test frame flagged in test mode");
  a_hold_reload: assert property
    (cond[C_SYNC_ALM] ##1 !cond[C_SYNC_ALM] |-> st.hold_cnt[C_SYNC_ALM] == HOLD_CYCLES
     ##1 st.hold_cnt[C_SYNC_ALM] == HOLD_CYCLES - 32'h00000001 || cond[C_SYNC_ALM])
    else $error("hold counter not reloaded or not counting");
  a_hold_keeps: assert property (st.hold_cnt[C_FRAME_ALM] != '0 |=> alarm)
    else $error("alarm released during hold");
  a_fuse_block: assert property
    (st.brk_sync[2] && st.brk_sync[1] |=> fuse_fail_block_out)
    else $error("breaker open did not block");
  a_local_age: assert property
    (pop |-> st.now - rd_data[FIFO_W-1:128] >= st.wait_limit)
    else $error("local sample released early");
  a_late_counts: assert property
    (!frame_valid && deadline && st.miss_cnt == 2'h1 |=> st.miss_cnt == 2'h2)
    else $error("late slot not counted");

  c_zoh: cover property (zoh);
  c_alarm_release: cover property (evt[E_ALARM_CLR]);
  c_local_out: cover property (local_out_valid);
  c_breaker: cover property ($rose(fuse_fail_block_out));
endmodule

// File: hdl/svrx_pkg.sv
// Contract
// - alarm on unknown or 100 ms sync accuracy
// - each cause held 10 s after clearing
// - alarm on two consecutive lost frames
// - single loss repeats last samples, no alarm or warning
// - wait limit sets when a frame counts late
// - local samples delayed by the wait limit
// - warning on sync accuracy worse than 4 us
// - warning while enabled adaptivity is not ready
// - warning always active while alarm is active
// - non-derived quality bit raises warning and alarm
// - test mode accepts test bit silently
// - breaker open drives fuse-fail block output
// - breaker input inactive by default
// - four signed 32-bit samples, reset to zero
package svrx_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_PERIOD     = 8'h04;
  localparam logic [7:0] ADDR_WAIT       = 8'h08;
  localparam logic [7:0] ADDR_SUPV       = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;

  localparam int CTRL_TEST_MODE = 0;
  localparam int CTRL_ADAPT_EN  = 1;
  localparam int SUPV_ALARM     = 0;
  localparam int SUPV_WARN      = 1;
  localparam int SUPV_FUSE      = 2;
  localparam int SUPV_CAUSE     = 3;
  localparam int SUPV_MISS      = 8;

  localparam logic [31:0] PERIOD_RST = 32'h0000f424;
  localparam logic [31:0] WAIT_RST   = 32'h0001e848;

  // ---------------------------------------------------------------
  // timing and thresholds
  // ---------------------------------------------------------------
  localparam longint CLK_KHZ       = 250_000;
  localparam longint HOLD_TIME_MS  = 10_000;
  localparam longint HOLD_CYCLES_L = HOLD_TIME_MS * CLK_KHZ;
  localparam logic [31:0] SYNC_ALARM_NS = 32'h05f5e100;
  localparam logic [31:0] SYNC_WARN_NS  = 32'h00000fa0;

  // ---------------------------------------------------------------
  // quality word, causes, events, delay buffer
  // ---------------------------------------------------------------
  localparam int QUAL_W           = 14;
  localparam int QUAL_TEST_BIT    = 11;
  localparam int QUAL_DERIVED_BIT = 13;

  localparam int C_SYNC_ALM  = 0;
  localparam int C_FRAME_ALM = 1;
  localparam int C_QUAL      = 2;
  localparam int C_SYNC_WARN = 3;
  localparam int C_ADAPT     = 4;
  localparam int N_CAUSE     = 5;

  localparam int E_ALARM_SET = 0;
  localparam int E_ALARM_CLR = 1;
  localparam int E_WARN_SET  = 2;
  localparam int E_ZOH       = 3;
  localparam int E_OVERFLOW  = 4;
  localparam int E_BREAKER   = 5;
  localparam int N_EVT       = 6;

  localparam int FIFO_AW = 4;
  localparam int FIFO_W  = 160;
endpackage
